/* File: design/kpm_pkg.sv */
// Package with register map, field layouts and constants of the key event detector.
package kpm_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFF_CFG    = 5'h00;
    localparam logic [4:0] OFF_KEYLO  = 5'h04;
    localparam logic [4:0] OFF_KEYHI  = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0c;
    localparam logic [4:0] OFF_MASK   = 5'h10;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int CFG_K1_LSB   = 0;
    localparam int CFG_K2_LSB   = 2;
    localparam int CFG_MODE_BIT = 4;
    localparam int ST_EV1_BIT   = 0;
    localparam int ST_EV2_BIT   = 1;
    localparam int LEN_W        = 2;
    localparam int BYTE_W       = 8;
    localparam int SEQ_MAX      = 3;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  LEN_OFF      = 2'h0;
    localparam logic        MODE_PM_KEY  = 1'h1;
    localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
    localparam logic [31:0] KEY_RESET    = 32'h0000_0000;
    localparam logic [1:0]  EVT_RESET    = 2'h0;
    localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
endpackage : kpm_pkg

/* File: design/kpm_seq_match.sv */
// Sequence matcher for one power management key event.
`timescale 1ns/1ps
module kpm_seq_match #(
    parameter int BYTE_W = 8,
    parameter int LEN_W  = 2
) (
    // Clock and reset.
    input  wire logic                core_clk_in,
    input  wire logic                resetn_in,
    // Configuration.
    input  wire logic                enable_in,
    input  wire logic [LEN_W-1:0]    seq_len_in,
    input  wire logic [BYTE_W-1:0]   seq_byte0_in,
    input  wire logic [BYTE_W-1:0]   seq_byte1_in,
    input  wire logic [BYTE_W-1:0]   seq_byte2_in,
    // Received keyboard bytes.
    input  wire logic                byte_valid_in,
    input  wire logic [BYTE_W-1:0]   byte_data_in,
    // Match pulse.
    output logic                     match_out
);
    // ------------------------------------------------------------------
    // Matching progress
    // ------------------------------------------------------------------
    logic [LEN_W-1:0]  progress;
    logic [BYTE_W-1:0] expect_byte;
    logic              hit;
    logic              hit_first;
    logic              last_byte;
    logic              active;
    logic [LEN_W-1:0]  next_progress;
    logic [LEN_W-1:0]  done_cnt;

    // A count left over from a longer, older length restarts the compare.
    assign done_cnt    = (progress >= seq_len_in) ? '0 : progress;
    // Expected byte is chosen by how many bytes already matched.
    assign expect_byte = (done_cnt == LEN_W'(0)) ? seq_byte0_in :
                         (done_cnt == LEN_W'(1)) ? seq_byte1_in : seq_byte2_in;
    assign active      = enable_in && (seq_len_in != kpm_pkg::LEN_OFF);
    assign hit         = byte_data_in == expect_byte;
    assign hit_first   = byte_data_in == seq_byte0_in;
    assign last_byte   = (done_cnt + LEN_W'(1)) == seq_len_in;
    // A mismatching byte may still start a fresh sequence.
    assign next_progress = hit ? LEN_W'(done_cnt + LEN_W'(1)) :
                           hit_first ? LEN_W'(1) : LEN_W'(0);

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            progress  <= '0;
            match_out <= 1'b0;
        end else if (!active) begin
            progress  <= '0;
            match_out <= 1'b0;
        end else if (byte_valid_in) begin
            match_out <= hit && last_byte;
            progress  <= (hit && last_byte) ? LEN_W'(0) : next_progress;
        end else begin
            match_out <= 1'b0;
        end
    end
endmodule : kpm_seq_match

/* File: design/kpm_key_event.sv */
// Top of the power management key event detector with Avalon-MM registers.
// Operation
// - Key-2 length: 00 disabled (default), 01 one, 10 two, 11 three bytes.
// - Key-2 length only acts while key mode selector equals one.
// - Key-2 sequence comes from stored bytes 3, 4, 5, starting at 3.
// - Separate key-1 length field; its detection flags key 1 pressed.
// - Key-1 length only acts while key mode selector equals one.
// - Detected key-2 sequence flags a press of key 2.
// - Key-1 sequence from stored bytes 0, 1, 2; length zero disables.
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module kpm_key_event (
    // Clock and reset.
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    // Avalon-MM slave.
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Keyboard byte stream.
    input  wire logic        kbd_byte_valid_in,
    input  wire logic [7:0]  kbd_byte_in,
    // Events and interrupt.
    output logic             key1_event_out,
    output logic             key2_event_out,
    output logic             irq_out
);
    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [1:0]  key1_seq_length;
    logic [1:0]  key2_seq_length;
    logic        detector_key_mode_sel;
    logic [7:0]  stored_key_byte [6];
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        ack;
    logic        match1;
    logic        match2;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    function automatic logic [7:0] lane(input logic [31:0] old_w, input int idx);
        lane = avs_byteenable_in[idx] ? avs_writedata_in[idx*8 +: 8] : old_w[idx*8 +: 8];
    endfunction : lane

    wire        req      = (avs_read_in || avs_write_in) && !ack;
    wire        wr_take  = avs_write_in && ack;
    wire        rd_take  = avs_read_in && !ack;
    wire        sel_cfg  = avs_address_in == kpm_pkg::OFF_CFG;
    wire        sel_klo  = avs_address_in == kpm_pkg::OFF_KEYLO;
    wire        sel_khi  = avs_address_in == kpm_pkg::OFF_KEYHI;
    wire        sel_st   = avs_address_in == kpm_pkg::OFF_STATUS;
    wire        sel_mask = avs_address_in == kpm_pkg::OFF_MASK;
    wire [31:0] cfg_word = {27'h0, detector_key_mode_sel, key2_seq_length, key1_seq_length};
    wire [31:0] klo_word = {8'h00, stored_key_byte[2], stored_key_byte[1], stored_key_byte[0]};
    wire [31:0] khi_word = {8'h00, stored_key_byte[5], stored_key_byte[4], stored_key_byte[3]};
    wire [31:0] rd_mux   = sel_cfg  ? cfg_word :
                           sel_klo  ? klo_word :
                           sel_khi  ? khi_word :
                           sel_st   ? {30'h0, status} :
                           sel_mask ? {30'h0, mask} : kpm_pkg::UNMAPPED_VAL;
    wire [31:0] new_cfg  = {lane(cfg_word, 3), lane(cfg_word, 2), lane(cfg_word, 1),
                            lane(cfg_word, 0)};
    wire [31:0] new_klo  = {lane(klo_word, 3), lane(klo_word, 2), lane(klo_word, 1),
                            lane(klo_word, 0)};
    wire [31:0] new_khi  = {lane(khi_word, 3), lane(khi_word, 2), lane(khi_word, 1),
                            lane(khi_word, 0)};
    wire [1:0]  w1c      = (wr_take && sel_st && avs_byteenable_in[0]) ?
                           avs_writedata_in[1:0] : 2'h0;
    wire        pm_mode  = detector_key_mode_sel == kpm_pkg::MODE_PM_KEY;

    // One wait cycle per access: waitrequest drops on the second cycle.
    // Waitrequest has a flop of its own so that the port leaves a register.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack                 <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= kpm_pkg::UNMAPPED_VAL;
        end else begin
            ack                 <= req;
            avs_waitrequest_out <= !req;
            if (rd_take) avs_readdata_out <= rd_mux;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            key1_seq_length       <= kpm_pkg::LEN_OFF;
            key2_seq_length       <= kpm_pkg::LEN_OFF;
            detector_key_mode_sel <= 1'b0;
            mask                  <= kpm_pkg::EVT_RESET;
        end else if (wr_take && sel_cfg) begin
            key1_seq_length       <= new_cfg[kpm_pkg::CFG_K1_LSB +: kpm_pkg::LEN_W];
            key2_seq_length       <= new_cfg[kpm_pkg::CFG_K2_LSB +: kpm_pkg::LEN_W];
            detector_key_mode_sel <= new_cfg[kpm_pkg::CFG_MODE_BIT];
        end else if (wr_take && sel_mask && avs_byteenable_in[0]) begin
            mask                  <= avs_writedata_in[1:0];
        end
    end

    // Stored key bytes, three per word.
    generate
        for (genvar i = 0; i < kpm_pkg::SEQ_MAX; i++) begin : g_keys
            always_ff @(posedge core_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    stored_key_byte[i]   <= kpm_pkg::KEY_RESET[7:0];
                    stored_key_byte[i+3] <= kpm_pkg::KEY_RESET[7:0];
                end else begin
                    if (wr_take && sel_klo) stored_key_byte[i]   <= new_klo[i*8 +: 8];
                    if (wr_take && sel_khi) stored_key_byte[i+3] <= new_khi[i*8 +: 8];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Sequence matchers
    // ------------------------------------------------------------------
    // key-1 bytes 0..2.
    kpm_seq_match #(.BYTE_W(kpm_pkg::BYTE_W), .LEN_W(kpm_pkg::LEN_W)) u_key1 (
        .core_clk_in   (core_clk_in),
        .resetn_in     (resetn_in),
        .enable_in     (pm_mode),
        .seq_len_in    (key1_seq_length),
        .seq_byte0_in  (stored_key_byte[0]),
        .seq_byte1_in  (stored_key_byte[1]),
        .seq_byte2_in  (stored_key_byte[2]),
        .byte_valid_in (kbd_byte_valid_in),
        .byte_data_in  (kbd_byte_in),
        .match_out     (match1)
    );
    kpm_seq_match #(.BYTE_W(kpm_pkg::BYTE_W), .LEN_W(kpm_pkg::LEN_W)) u_key2 (
        .core_clk_in   (core_clk_in),
        .resetn_in     (resetn_in),
        .enable_in     (pm_mode),
        .seq_len_in    (key2_seq_length),
        .seq_byte0_in  (stored_key_byte[3]),
        .seq_byte1_in  (stored_key_byte[4]),
        .seq_byte2_in  (stored_key_byte[5]),
        .byte_valid_in (kbd_byte_valid_in),
        .byte_data_in  (kbd_byte_in),
        .match_out     (match2)
    );

    // Sticky status: a new event wins over a write-one clear.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status         <= kpm_pkg::EVT_RESET;
            key1_event_out <= 1'b0;
            key2_event_out <= 1'b0;
            irq_out        <= 1'b0;
        end else begin
            status         <= (status & ~w1c) | {match2, match1};
            key1_event_out <= match1;
            key2_event_out <= match2;
            irq_out        <= |(((status & ~w1c) | {match2, match1}) & mask);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_disabled1;
        !pm_mode || key1_seq_length == kpm_pkg::LEN_OFF;
    endsequence
    property p_off_quiet;
        @(posedge core_clk_in) disable iff (!resetn_in)
            s_disabled1 ##1 s_disabled1 |=> !key1_event_out;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("key1 event while disabled");

    property p_len1_key2;
        @(posedge core_clk_in) disable iff (!resetn_in)
            (pm_mode && key2_seq_length == 2'h1 && kbd_byte_valid_in &&
             kbd_byte_in == stored_key_byte[3]) |-> ##2 key2_event_out;
    endproperty
    a_len1_key2: assert property (p_len1_key2) else $error("one byte key2 missed");

    property p_mode_gate;
        @(posedge core_clk_in) disable iff (!resetn_in)
            (!pm_mode) [*3] |-> !key2_event_out && !key1_event_out;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("event outside key mode");

    property p_sticky;
        @(posedge core_clk_in) disable iff (!resetn_in)
            key2_event_out |-> status[kpm_pkg::ST_EV2_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("key2 status not set");

    property p_irq;
        @(posedge core_clk_in) disable iff (!resetn_in)
            (|(status & mask)) && w1c == 2'h0 |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    sequence s_key1_single;
        pm_mode && key1_seq_length == 2'h1 && kbd_byte_valid_in &&
        kbd_byte_in == stored_key_byte[0];
    endsequence
    property p_len1_key1;
        @(posedge core_clk_in) disable iff (!resetn_in)
            s_key1_single |-> ##2 key1_event_out;
    endproperty
    a_len1_key1: assert property (p_len1_key1) else $error("one byte key1 missed");

    property p_key1_cause;
        @(posedge core_clk_in) disable iff (!resetn_in)
            key1_event_out |-> $past(pm_mode, 2) &&
                               $past(key1_seq_length, 2) != kpm_pkg::LEN_OFF;
    endproperty
    a_key1_cause: assert property (p_key1_cause) else $error("key1 event without enable");

    property p_key2_cause;
        @(posedge core_clk_in) disable iff (!resetn_in)
            key2_event_out |-> $past(pm_mode, 2) &&
                               $past(key2_seq_length, 2) != kpm_pkg::LEN_OFF;
    endproperty
    a_key2_cause: assert property (p_key2_cause) else $error("key2 event without enable");

    property p_clear1;
        @(posedge core_clk_in) disable iff (!resetn_in)
            w1c[kpm_pkg::ST_EV1_BIT] && !match1 |=> !status[kpm_pkg::ST_EV1_BIT];
    endproperty
    a_clear1: assert property (p_clear1) else $error("key1 flag not cleared");
endmodule : kpm_key_event

/* File: verif/kpm_kbd_model.sv */
// Keyboard byte source that feeds received bytes to the detector.
`timescale 1ns/1ps
module kpm_kbd_model (
    // Clock.
    input  wire logic  core_clk_in,
    // Byte stream.
    output logic       kbd_byte_valid_out,
    output logic [7:0] kbd_byte_out
);
    // The idle line starts with valid low and a data pattern that stored byte 2 can also take.
    initial begin
        kbd_byte_valid_out = 1'b0;
        kbd_byte_out       = 8'h5a;
    end

    // Releases the line; stale data is inverted so it differs from the byte last presented.
    task automatic idle();
        kbd_byte_valid_out <= 1'b0;
        kbd_byte_out       <= ~kbd_byte_out;
    endtask : idle

    // Presents one byte for one cycle, after an idle gap when the gap is nonzero.
    task automatic send(input logic [7:0] b, input int gap);
        if (gap > 0) begin
            idle();
            repeat (gap) @(posedge core_clk_in);
        end
        kbd_byte_valid_out <= 1'b1;
        kbd_byte_out       <= b;
        @(posedge core_clk_in);
    endtask : send
endmodule : kpm_kbd_model

/* File: verif/testbench.sv */
// Self-checking testbench of the key event detector.
`timescale 1ns/1ps
module testbench;
    logic        core_clk_in, resetn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [4:0]  avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, seed, rd, r;
    logic [3:0]  avs_byteenable_in;
    logic        kbd_byte_valid_in, key1_event_out, key2_event_out, irq_out, mode;
    logic [7:0]  kbd_byte_in;
    logic [7:0]  b [6];
    logic [1:0]  l1, l2, m, st;
    int          err_count, comparisons, hits1, hits2, h1, h2;

    kpm_key_event uut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .kbd_byte_valid_in(kbd_byte_valid_in),
        .kbd_byte_in(kbd_byte_in), .key1_event_out(key1_event_out),
        .key2_event_out(key2_event_out), .irq_out(irq_out));
    kpm_kbd_model kbd (.core_clk_in(core_clk_in), .kbd_byte_valid_out(kbd_byte_valid_in),
        .kbd_byte_out(kbd_byte_in));

    // Clock at 250 MHz.
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end

    // Counts event pulses as they appear.
    always @(posedge core_clk_in) begin
        if (key1_event_out === 1'b1) hits1 <= hits1 + 1;
        if (key2_event_out === 1'b1) hits2 <= hits2 + 1;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Events expected from a wrong-order then a right-order sequence.
    function automatic logic [31:0] exp_hits(input logic md, input logic [1:0] len);
        if (md !== 1'b1 || len == 2'h0) return 32'h0;
        return (len == 2'h1) ? 32'h2 : 32'h1;
    endfunction : exp_hits

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Bus access holds the request until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        do begin
            @(posedge core_clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : bus

    task automatic seq(input int x, input int y, input int z);
        kbd.send(b[x], int'(xs() % 3));
        kbd.send(b[y], int'(xs() % 3));
        kbd.send(b[z], int'(xs() % 3));
    endtask : seq

    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge core_clk_in);
        err_count++;
        tally_and_finish();
    end

    initial begin
        {resetn_in, avs_read_in, avs_write_in, avs_address_in} = '0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hf;
        seed = 32'h53d6;
        {err_count, comparisons, hits1, hits2} = '0;
        repeat (16) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        bus(1'b0, kpm_pkg::OFF_CFG, 32'h0);
        check(rd, kpm_pkg::CFG_RESET);
        bus(1'b0, kpm_pkg::OFF_KEYHI, 32'h0);
        check(rd, kpm_pkg::KEY_RESET);
        bus(1'b0, kpm_pkg::OFF_STATUS, 32'h0);
        check(rd, {30'h0, kpm_pkg::EVT_RESET});
        bus(1'b1, 5'h14, 32'hffff_ffff);
        bus(1'b0, 5'h14, 32'h0);
        check(rd, kpm_pkg::UNMAPPED_VAL);
        // A write with lane 0 switched off leaves the length fields alone.
        avs_byteenable_in <= 4'he;
        bus(1'b1, kpm_pkg::OFF_CFG, 32'h0000_001f);
        avs_byteenable_in <= 4'hf;
        bus(1'b0, kpm_pkg::OFF_CFG, 32'h0);
        check(rd, kpm_pkg::CFG_RESET);
        $display("test reset_values done");
        for (int i = 0; i < 32; i++) begin
            {mode, l2, l1} = 5'(i);
            r = xs();
            m = r[31:30];
            for (int j = 0; j < 6; j++) b[j] = {r[4*j +: 5], 3'(j)};
            bus(1'b1, kpm_pkg::OFF_KEYLO, {8'h00, b[2], b[1], b[0]});
            bus(1'b1, kpm_pkg::OFF_KEYHI, {8'h00, b[5], b[4], b[3]});
            bus(1'b1, kpm_pkg::OFF_CFG, {27'h0, mode, l2, l1});
            bus(1'b0, kpm_pkg::OFF_CFG, 32'h0);
            check(rd, {27'h0, mode, l2, l1});
            bus(1'b1, kpm_pkg::OFF_MASK, {30'h0, m});
            h1 = hits1;
            h2 = hits2;
            seq(0, 2, 1);
            seq(0, 1, 2);
            seq(3, 5, 4);
            seq(3, 4, 5);
            kbd.idle();
            repeat (6) @(posedge core_clk_in);
            check(32'(hits1 - h1), exp_hits(mode, l1));
            check(32'(hits2 - h2), exp_hits(mode, l2));
            st = {exp_hits(mode, l2) != 0, exp_hits(mode, l1) != 0};
            bus(1'b0, kpm_pkg::OFF_STATUS, 32'h0);
            check(rd, {30'h0, st});
            check({31'h0, irq_out}, {31'h0, |(st & m)});
            bus(1'b1, kpm_pkg::OFF_STATUS, 32'h3);
            bus(1'b0, kpm_pkg::OFF_STATUS, 32'h0);
            check({rd[31:0]}, 32'h0);
            check({31'h0, irq_out}, 32'h0);
        end
        $display("test sequence_sweep done");
        tally_and_finish();
    end
endmodule : testbench
